// file: hw/irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [3:0]            pin_event,
	input  wire logic [3:0]            periph_event,
	input  wire logic                  instr_cycle_en,
	input  wire logic                  return_from_service_instruction,
	input  wire logic [20:0]           return_pc,
	output logic                       vector_take,
	output logic      [20:0]           vector_addr,
	output logic                       stack_push,
	output logic      [20:0]           stack_push_addr,
	output logic                       high_active,
	output logic                       irq
);
	// ====================================================
	// state
	typedef struct packed {
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
		logic        hi_gate;        // high_level_global_enable / global_interrupt_enable
		logic        lo_gate;        // low_level_global_enable / peripheral_group_enable
		logic        prio_mode;      // priority_scheme_enable
		logic [7:0]  flag;
		logic [7:0]  en;
		logic [7:0]  prio;
		logic [7:0]  periph;         // 1 = peripheral source
		logic [2:0]  status;
		logic [2:0]  irq_en;
		logic        in_high;
		logic        in_low;
		logic        take;
		logic [20:0] vaddr;
		logic        push;
		logic [20:0] push_addr;
		logic        irq;
		logic [3:0]  pin_s1;
		logic [3:0]  pin_s2;
		logic [3:0]  pin_s3;
		logic [3:0]  pend_pin;
		logic [1:0]  lat_cnt;
	} state_t;

	state_t s_q, s_d;

	logic        acc;
	logic        wr;
	logic [7:0]  evt;
	logic [7:0]  elig_hi;
	logic [7:0]  elig_lo;
	logic        req_hi;
	logic        req_lo;
	logic [3:0]  pin_edge;

	// ====================================================
	// next state
	always_comb begin
		s_d      = s_q;
		acc      = psel && penable && !s_q.ready;
		wr       = psel && penable && s_q.ready && pwrite;    // write lands while pready stands
		s_d.take = 1'b0;
		s_d.push = 1'b0;
		s_d.ready = 1'b0;
		// pin input sync, edge detect on second stage
		s_d.pin_s1 = pin_event;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.pin_s3 = s_q.pin_s2;
		pin_edge   = s_q.pin_s2 & ~s_q.pin_s3;
		// pin events wait a fixed instruction-cycle count
		s_d.pend_pin = s_q.pend_pin | pin_edge;
		evt = {periph_event, 4'h0};
		if (s_q.pend_pin != 4'h0 && instr_cycle_en) begin
			if (s_q.lat_cnt == 2'(irq_ctrl_pkg::PIN_LAT_CYC - 2)) begin
				evt[3:0]     = s_q.pend_pin;
				s_d.pend_pin = pin_edge;
				s_d.lat_cnt  = 2'd0;
			end else begin
				s_d.lat_cnt = s_q.lat_cnt + 2'd1;
			end
		end
		// eligibility per source
		for (int i = 0; i < irq_ctrl_pkg::NSRC; i++) begin
			if (s_q.prio_mode) begin
				elig_hi[i] = s_q.flag[i] && s_q.en[i] && s_q.prio[i] && s_q.hi_gate;
				elig_lo[i] = s_q.flag[i] && s_q.en[i] && !s_q.prio[i] && s_q.lo_gate;
			end else begin
				elig_hi[i] = s_q.flag[i] && s_q.en[i] && s_q.hi_gate
					&& (!s_q.periph[i] || s_q.lo_gate);
				elig_lo[i] = 1'b0;
			end
		end
		req_hi = |elig_hi;
		req_lo = |elig_lo && !s_q.in_high && !s_q.in_low;
		// return from service
		if (return_from_service_instruction) begin
			s_d.status[irq_ctrl_pkg::EV_RET] = 1'b1;
			if (s_q.in_high) begin
				s_d.in_high = 1'b0;
				s_d.hi_gate = 1'b1;
			end else if (s_q.in_low) begin
				s_d.in_low  = 1'b0;
				s_d.lo_gate = 1'b1;
			end else begin
				s_d.hi_gate = 1'b1;
			end
		end else if (req_hi) begin
			s_d.take      = 1'b1;
			s_d.vaddr     = irq_ctrl_pkg::VEC_HIGH;
			s_d.push      = 1'b1;
			s_d.push_addr = return_pc;
			s_d.hi_gate   = 1'b0;
			s_d.in_high   = s_q.prio_mode;
			s_d.status[irq_ctrl_pkg::EV_HIGH] = 1'b1;
		end else if (req_lo) begin
			s_d.take      = 1'b1;
			s_d.vaddr     = irq_ctrl_pkg::VEC_LOW;
			s_d.push      = 1'b1;
			s_d.push_addr = return_pc;
			s_d.lo_gate   = 1'b0;
			s_d.in_low    = 1'b1;
			s_d.status[irq_ctrl_pkg::EV_LOW] = 1'b1;
		end
		// register writes, taken at the edge that sees pready high
		if (wr) begin
			unique case (paddr)
				irq_ctrl_pkg::OFS_CTRL: begin
					s_d.hi_gate   = pwdata[irq_ctrl_pkg::B_HI_GATE];
					s_d.lo_gate   = pwdata[irq_ctrl_pkg::B_LO_GATE];
					s_d.prio_mode = pwdata[irq_ctrl_pkg::B_RST_SHIFT + irq_ctrl_pkg::B_PRIO_MODE];
				end
				irq_ctrl_pkg::OFS_FLAG:    s_d.flag   = pwdata[7:0];
				irq_ctrl_pkg::OFS_ENABLE:  s_d.en     = pwdata[7:0];
				irq_ctrl_pkg::OFS_PRIO:    s_d.prio   = pwdata[7:0];
				irq_ctrl_pkg::OFS_PERIPH:  s_d.periph = pwdata[7:0];
				irq_ctrl_pkg::OFS_IRQ_EN:  s_d.irq_en = pwdata[2:0];
				irq_ctrl_pkg::OFS_IRQ_CLR: s_d.status = s_q.status & ~pwdata[2:0];
				default: ;
			endcase
		end
		// hardware sets win over software clears
		s_d.flag = s_d.flag | evt;
		if (s_d.take && s_d.vaddr == irq_ctrl_pkg::VEC_HIGH)
			s_d.status[irq_ctrl_pkg::EV_HIGH] = 1'b1;
		if (s_d.take && s_d.vaddr == irq_ctrl_pkg::VEC_LOW)
			s_d.status[irq_ctrl_pkg::EV_LOW] = 1'b1;
		if (return_from_service_instruction)
			s_d.status[irq_ctrl_pkg::EV_RET] = 1'b1;
		s_d.irq = |(s_d.status & s_d.irq_en);
		// read and answer
		if (acc) begin
			s_d.ready  = 1'b1;
			s_d.slverr = 1'b0;
			s_d.rdata  = 32'h0;
			unique case (paddr)
				irq_ctrl_pkg::OFS_CTRL:    s_d.rdata = {16'h0, s_q.prio_mode, 7'h0, s_q.hi_gate, s_q.lo_gate, 6'h0};
				irq_ctrl_pkg::OFS_FLAG:    s_d.rdata = {24'h0, s_q.flag};
				irq_ctrl_pkg::OFS_ENABLE:  s_d.rdata = {24'h0, s_q.en};
				irq_ctrl_pkg::OFS_PRIO:    s_d.rdata = {24'h0, s_q.prio};
				irq_ctrl_pkg::OFS_PERIPH:  s_d.rdata = {24'h0, s_q.periph};
				irq_ctrl_pkg::OFS_STATUS:  s_d.rdata = {29'h0, s_q.status};
				irq_ctrl_pkg::OFS_IRQ_EN:  s_d.rdata = {29'h0, s_q.irq_en};
				irq_ctrl_pkg::OFS_IRQ_CLR: s_d.rdata = 32'h0;
				default:                   s_d.slverr = 1'b1;
			endcase
		end else begin
			s_d.slverr = 1'b0;
		end
	end

	// ====================================================
	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops
	assign prdata          = s_q.rdata;
	assign pready          = s_q.ready;
	assign pslverr         = s_q.slverr;
	assign vector_take     = s_q.take;
	assign vector_addr     = s_q.vaddr;
	assign stack_push      = s_q.push;
	assign stack_push_addr = s_q.push_addr;
	assign high_active     = s_q.in_high;
	assign irq             = s_q.irq;
endmodule : irq_ctrl
`default_nettype wire

// file: hw/irq_ctrl_pkg.sv
// Contract
// - high vector 0x08, low vector 0x18
// - high request preempts running low routine
// - each source: flag, enable, priority bit
// - priority scheme enable bit 7, reset clear; code uses CTRL bit 15 (B_RST_SHIFT + B_PRIO_MODE)
// - high enable gates high, low gates low
// - flag, enable, global set: vector at once
// - compatibility mode ignores priority bits
// - compat: bit6 peripheral gate, bit7 global
// - compat: every interrupt goes to 0x08
// - accepting clears the governing global enable
// - no low service during high routine
// - entry pushes return address, loads vector
// - return instruction sets enable again
// - pin events vector in three-four cycles
// - flags set regardless of enables
package irq_ctrl_pkg;
	// ====================================================
	// sizes
	localparam int         NSRC         = 8;
	localparam int         NPIN         = 4;
	localparam int         PC_W         = 21;
	// ====================================================
	// vectors
	localparam logic [20:0] VEC_HIGH    = 21'h000008;
	localparam logic [20:0] VEC_LOW     = 21'h000018;
	// ====================================================
	// apb register offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_FLAG     = 8'h04;
	localparam logic [7:0] OFS_ENABLE   = 8'h08;
	localparam logic [7:0] OFS_PRIO     = 8'h0c;
	localparam logic [7:0] OFS_PERIPH   = 8'h10;
	localparam logic [7:0] OFS_STATUS   = 8'h14;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h1c;
	// ====================================================
	// control register fields
	localparam int         B_HI_GATE    = 7;
	localparam int         B_LO_GATE    = 6;
	localparam int         B_PRIO_MODE  = 7;
	localparam int         B_RST_SHIFT  = 8;
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	// event status bits
	localparam int         EV_HIGH      = 0;
	localparam int         EV_LOW       = 1;
	localparam int         EV_RET       = 2;
	localparam int         NEV          = 3;
	// ====================================================
	// pin event latency, in instruction cycles
	localparam int         PIN_LAT_CYC  = 3;
endpackage : irq_ctrl_pkg

// file: test/irq_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        vector_take,
	input wire logic [20:0] vector_addr,
	input wire logic        stack_push,
	input wire logic        high_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// =====
	// bus and vector steps
	sequence s_req; psel && penable && !pready; endsequence
	sequence s_ans; pready ##1 !pready; endsequence
	sequence s_hi; vector_take && vector_addr == irq_ctrl_pkg::VEC_HIGH; endsequence
	sequence s_lo; vector_take && vector_addr == irq_ctrl_pkg::VEC_LOW; endsequence
	AST_APB_ANSWER: assert property (s_req |=> s_ans) else $error("apb answer late");
	AST_APB_CAUSE: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
	AST_ERR_QUAL: assert property (pslverr |-> pready) else $error("error without ready");
	AST_VEC_ADDR: assert property (vector_take |-> s_hi or s_lo) else $error("bad vector");
	AST_PUSH_PAIR: assert property (vector_take == stack_push) else $error("push unpaired");
	AST_HI_ONCE: assert property (s_hi |=> !vector_take) else $error("enable kept");
	AST_LO_ONCE: assert property (s_lo |=> not s_lo) else $error("low enable kept");
	AST_NO_LO_IN_HI: assert property (high_active |-> not s_lo) else $error("low in high");
endmodule : irq_ctrl_chk
bind irq_ctrl irq_ctrl_chk u_irq_ctrl_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.vector_take, .vector_addr, .stack_push, .high_active);
`default_nettype wire

// file: test/core_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_seq_model #(
	parameter int DIV = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ret_go,
	output logic             instr_cycle_en,
	output logic             ret_pulse,
	output logic      [20:0] return_pc
);
	int cnt;
	// =====
	// instruction ticks, running pc, return on request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			instr_cycle_en <= 1'b0;
			ret_pulse <= 1'b0;
			return_pc <= 21'h000100;
		end else begin
			cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
			instr_cycle_en <= (cnt == DIV - 1);
			ret_pulse <= ret_go;
			return_pc <= return_pc + 21'h000002;
		end
	end
endmodule : core_seq_model
`default_nettype wire

// file: test/two_level_interrupt_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ret_go, icyc, rets, vtake, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pin_ev, per_ev, pe;
	logic [20:0] rpc, vaddr, spa, qv[$];
	logic [32:0] qr[$];
	int          err_count, num_checks, n;
	irq_ctrl u_irq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .pin_event(pin_ev), .periph_event(per_ev), .instr_cycle_en(icyc),
		.return_from_service_instruction(rets), .return_pc(rpc), .vector_take(vtake),
		.vector_addr(vaddr), .stack_push(), .stack_push_addr(spa), .high_active(), .irq);
	core_seq_model u_core_seq_model (.pclk, .presetn, .ret_go, .instr_cycle_en(icyc),
		.ret_pulse(rets), .return_pc(rpc));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// =====
	// bus cycle, expected answer noted first
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge pclk);
		qr.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask : rd
	task automatic ret;
		@(posedge pclk);
		ret_go <= 1'b1;
		@(posedge pclk);
		ret_go <= 1'b0;
	endtask : ret
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test
	// compare each answer with the oldest note
	always @(posedge pclk) begin
		if (pready === 1'b1) chk(pwrite ? {pslverr, 32'h0} : {pslverr, prdata}, qr.pop_front());
		if (vtake === 1'b1) chk({12'h0, vaddr}, {12'h0, qv.pop_front()});
		if (vtake === 1'b1) chk({12'h0, spa}, {12'h0, rpc - 21'h000002});
	end
	initial begin
		#2000000;
		err_count++;
		end_of_test;
	end
	initial begin
		{presetn, psel, penable, pwrite, ret_go, paddr, pwdata, pin_ev, per_ev} = '0;
		void'($urandom(39947));
		pe = 4'($urandom_range(15, 1));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(irq_ctrl_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, 8'h20, 32'h5a, {1'b1, 32'h0});
		rd(irq_ctrl_pkg::OFS_ENABLE, 32'h0);
		$display("reset test done");
		wr(irq_ctrl_pkg::OFS_PRIO, $urandom & 32'hff);
		wr(irq_ctrl_pkg::OFS_PERIPH, 32'hf0);
		wr(irq_ctrl_pkg::OFS_ENABLE, 32'hff);
		@(posedge pclk);
		per_ev <= pe;
		@(posedge pclk);
		per_ev <= 4'h0;
		rd(irq_ctrl_pkg::OFS_FLAG, {24'h0, pe, 4'h0});
		wr(irq_ctrl_pkg::OFS_CTRL, 32'h80);
		rd(irq_ctrl_pkg::OFS_CTRL, 32'h80);
		wr(irq_ctrl_pkg::OFS_FLAG, 32'h0);
		wr(irq_ctrl_pkg::OFS_CTRL, 32'hc0);
		qv.push_back(irq_ctrl_pkg::VEC_HIGH);
		n = 0;
		pin_ev <= 4'h1;
		for (int i = 0; i < 200 && vtake !== 1'b1; i++) begin
			@(posedge pclk);
			n += int'(icyc);
		end
		pin_ev <= 4'h0;
		chk(33'(n <= 4), 33'h1);
		rd(irq_ctrl_pkg::OFS_CTRL, 32'h40);
		wr(irq_ctrl_pkg::OFS_FLAG, 32'h0);
		ret;
		rd(irq_ctrl_pkg::OFS_CTRL, 32'hc0);
		$display("compat test done");
		wr(irq_ctrl_pkg::OFS_PRIO, 32'h01);
		wr(irq_ctrl_pkg::OFS_ENABLE, 32'h11);
		wr(irq_ctrl_pkg::OFS_IRQ_EN, 32'h7);
		wr(irq_ctrl_pkg::OFS_CTRL, 32'h80c0);
		qv.push_back(irq_ctrl_pkg::VEC_HIGH);
		wr(irq_ctrl_pkg::OFS_FLAG, 32'h11);
		wr(irq_ctrl_pkg::OFS_FLAG, 32'h10);
		rd(irq_ctrl_pkg::OFS_CTRL, 32'h8040);
		qv.push_back(irq_ctrl_pkg::VEC_LOW);
		ret;
		rd(irq_ctrl_pkg::OFS_CTRL, 32'h8080);
		qv.push_back(irq_ctrl_pkg::VEC_HIGH);
		wr(irq_ctrl_pkg::OFS_FLAG, 32'h01);
		rd(irq_ctrl_pkg::OFS_CTRL, 32'h8000);
		rd(irq_ctrl_pkg::OFS_STATUS, 32'h7);
		repeat (2) @(posedge pclk);
		chk({32'h0, irq}, 33'h1);
		wr(irq_ctrl_pkg::OFS_IRQ_EN, 32'h0);
		repeat (2) @(posedge pclk);
		chk({32'h0, irq}, 33'h0);
		wr(irq_ctrl_pkg::OFS_IRQ_CLR, 32'h7);
		rd(irq_ctrl_pkg::OFS_STATUS, 32'h0);
		repeat (4) @(posedge pclk);
		chk(33'(qv.size()), 33'h0);
		$display("priority test done");
		end_of_test;
	end
endmodule : two_level_interrupt_controller_tb
`default_nettype wire
